/* sim/tb_rsx_exec.sv */
/*
  tb_rsx_exec: self-checking bench for the rsx_exec execute stage.
  assumes: rsx_pkg and rsx_exec are compiled first; the bench alone drives
  every input, acting as decoder, fetch unit and register master.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench
  import rsx_pkg::*;
;
  logic mclk_in;
  logic srst_in;
  logic ce_in;
  logic op_valid_in;
  rsx_issue_t iss_in;
  logic op_ready_out;
  logic mem_we_out;
  logic [7:0] mem_wdata_out;
  logic [7:0] acc_out;
  rsx_flags_t flags_out;
  logic skip_out;
  logic done_out;
  logic [1:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  int mismatches;
  int checks_done;
  int taken_cnt;
  logic [7:0] e_acc;
  rsx_flags_t e_fl;
  // operand rows: borrow, signed overflow, skip edges, equal operands
  localparam logic [7:0] MEM_TAB [5] = '{8'h01, 8'h80, 8'hff, 8'h00, 8'h5a};
  localparam logic [7:0] ACC_TAB [5] = '{8'h00, 8'h7f, 8'h80, 8'h01, 8'h5a};
  localparam logic [7:0] IMM_TAB [5] = '{8'h01, 8'hff, 8'h80, 8'h00, 8'ha5};

  rsx_exec #(.SKIP_CNT_W(8)) DUT (
    .mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in),
    .op_valid_in(op_valid_in), .iss_in(iss_in),
    .op_ready_out(op_ready_out), .mem_we_out(mem_we_out),
    .mem_wdata_out(mem_wdata_out), .acc_out(acc_out),
    .flags_out(flags_out), .skip_out(skip_out), .done_out(done_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out)
  );

  // 100 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // compare and count; report a mismatch at once
  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // reference subtract: x + ~y + ci with its four flags
  function automatic void sub8(input logic [7:0] x, input logic [7:0] y,
                               input logic ci, output logic [7:0] r,
                               output rsx_flags_t f);
    logic [8:0] s;
    logic [4:0] lo;
    s = {1'b0, x} + {1'b0, ~y} + {8'h00, ci};
    lo = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
    r = s[7:0];
    f.c = s[8];
    f.ac = lo[4];
    f.z = (s[7:0] == 8'h00);
    f.ov = (x[7] != y[7]) && (s[7] != x[7]);
  endfunction

  // reference model: updates e_acc and e_fl, returns write and skip
  function automatic void model(input rsx_op_t op, input logic [7:0] m,
                                input logic [7:0] im, input logic [2:0] bs,
                                output logic we, output logic [7:0] wd,
                                output logic sk);
    logic [7:0] r;
    sk = 1'b0;
    r = 8'h00;
    case (op)
      OP_RLC_MEM, OP_RLC_ACC: begin
        r = {m[6:0], e_fl.c};
        e_fl.c = m[7];
      end
      OP_RR_MEM, OP_RR_ACC: r = {m[0], m[7:1]};
      OP_RRC_MEM, OP_RRC_ACC: begin
        r = {e_fl.c, m[7:1]};
        e_fl.c = m[0];
      end
      OP_SBC_ACC, OP_SBC_MEM: sub8(e_acc, m, e_fl.c, r, e_fl);
      OP_DSZ_MEM, OP_DSZ_ACC: r = m - 8'h01;
      OP_ISZ_MEM, OP_ISZ_ACC: r = m + 8'h01;
      OP_SKIP_BIT_NZ: sk = m[bs];
      OP_SET_BYTE: r = 8'hff;
      OP_SET_BIT: r = m | (8'h01 << bs);
      OP_SUB_ACC, OP_SUB_MEM: sub8(e_acc, m, 1'b1, r, e_fl);
      OP_SUB_IMM: sub8(e_acc, im, 1'b1, r, e_fl);
      OP_SWAP: r = {m[3:0], m[7:4]};
      default: r = 8'h00;
    endcase
    if (op inside {OP_DSZ_MEM, OP_DSZ_ACC, OP_ISZ_MEM, OP_ISZ_ACC}) begin
      sk = (r == 8'h00);
    end
    we = op inside {OP_RLC_MEM, OP_RR_MEM, OP_RRC_MEM, OP_SBC_MEM,
                    OP_DSZ_MEM, OP_ISZ_MEM, OP_SET_BYTE, OP_SET_BIT,
                    OP_SUB_MEM, OP_SWAP};
    wd = r;
    if (op inside {OP_RLC_ACC, OP_RR_ACC, OP_RRC_ACC, OP_SBC_ACC,
                   OP_DSZ_ACC, OP_ISZ_ACC, OP_SUB_ACC, OP_SUB_IMM}) begin
      e_acc = r;
    end
  endfunction

  // issue one instruction, check its retirement and any dummy cycle
  task automatic run_op(input rsx_op_t op, input logic [7:0] m,
                        input logic [7:0] im, input logic [2:0] bs);
    logic we;
    logic [7:0] wd;
    logic sk;
    model(op, m, im, bs, we, wd, sk);
    @(posedge mclk_in);
    op_valid_in <= 1'b1;
    iss_in <= {op, m, im, bs};
    @(posedge mclk_in);
    // a set-byte offer during the dummy cycle must be ignored
    op_valid_in <= sk;
    iss_in <= {OP_SET_BYTE, 8'h00, 8'h00, 3'h0};
    #1;
    chk("mem_we", 8'(mem_we_out), 8'(we));
    if (we) begin
      chk("mem_wdata", mem_wdata_out, wd);
    end
    chk("acc", acc_out, e_acc);
    chk("flags", {4'h0, flags_out}, {4'h0, e_fl});
    chk("skip", 8'(skip_out), 8'(sk));
    chk("done", 8'(done_out), 8'(!sk));
    chk("ready", 8'(op_ready_out), 8'(!sk));
    if (sk) begin
      taken_cnt++;
      @(posedge mclk_in);
      op_valid_in <= 1'b0;
      #1;
      chk("dummy_we", 8'(mem_we_out), 8'h00);
      chk("dummy_done", 8'(done_out), 8'h01);
      chk("dummy_skip", 8'(skip_out), 8'h00);
    end
  endtask

  // register port write: one strobe cycle
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  // register port read: data in the next cycle only, zero after
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp,
                        input string name);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(name, reg_rdata_out, exp);
    @(posedge mclk_in);
    #1;
    chk("rdata_idle", reg_rdata_out, 8'h00);
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge mclk_in);
    mismatches++;
    end_sim;
  end

  // main sequence
  initial begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    op_valid_in = 1'b0;
    iss_in = '0;
    reg_addr_in = 2'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    mismatches = 0;
    checks_done = 0;
    taken_cnt = 0;
    e_acc = ACC_RST;
    e_fl = FLAGS_RST;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk("acc_rst", acc_out, ACC_RST);
    chk("ready_rst", 8'(op_ready_out), 8'h01);
    reg_rd(REG_STATUS, 8'h00, "status_rst");
    reg_rd(REG_SKIPS, 8'h00, "skips_rst");
    // unmapped address reads zero and ignores writes
    reg_wr(2'h3, 8'h5a);
    reg_rd(2'h3, 8'h00, "unmapped");
    reg_rd(REG_ACC, 8'h00, "acc_kept");
    // clock enable low: an offered instruction does nothing
    @(posedge mclk_in);
    ce_in <= 1'b0;
    op_valid_in <= 1'b1;
    iss_in <= {OP_SET_BYTE, 8'h00, 8'h00, 3'h0};
    repeat (2) @(posedge mclk_in);
    #1;
    chk("frozen_we", 8'(mem_we_out), 8'h00);
    @(posedge mclk_in);
    ce_in <= 1'b1;
    op_valid_in <= 1'b0;
    // every opcode, plus one unused code, over all operand rows
    for (int k = 0; k < 21; k++) begin
      for (int i = 0; i < 5; i++) begin
        e_acc = ACC_TAB[i];
        e_fl = rsx_flags_t'(4'(i + k));
        reg_wr(REG_ACC, e_acc);
        reg_wr(REG_STATUS, {4'h0, e_fl});
        run_op((k == 20) ? rsx_op_t'(5'h1f) : rsx_op_t'(k[4:0]),
               MEM_TAB[i], IMM_TAB[i], 3'(i * 3));
      end
      reg_rd(REG_ACC, e_acc, "acc_reg");
      reg_rd(REG_STATUS, {4'h0, e_fl}, "status_reg");
    end
    reg_rd(REG_SKIPS, taken_cnt[7:0], "skip_count");
    reg_wr(REG_SKIPS, 8'h00);
    reg_rd(REG_SKIPS, 8'h00, "skip_clear");
    end_sim;
  end
endmodule

`default_nettype wire

/* src/rsx_exec.sv */
/*
  rsx_exec: execute stage for rotates, subtractions, skip-on-zero,
  skip-on-bit, byte and bit set, and nibble swap of an 8-bit core.
  assumes: the decoder hands one instruction per handshake with the memory
  byte already read; the memory write port, the fetch unit (which acts on
  skip_out) and the register master all run on mclk_in.
*/
// The address map and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none

module rsx_exec
  import rsx_pkg::*;
#(
  parameter int SKIP_CNT_W = 8
) (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic op_valid_in,
  input wire rsx_issue_t iss_in,
  output logic op_ready_out,
  output logic mem_we_out,
  output logic [7:0] mem_wdata_out,
  output logic [7:0] acc_out,
  output rsx_flags_t flags_out,
  output logic skip_out,
  output logic done_out,
  input wire logic [1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);

  // the skip counter is read back through an 8-bit register
  if (SKIP_CNT_W < 1 || SKIP_CNT_W > 8) begin : g_chk
    $error("rsx_exec: SKIP_CNT_W must lie in 1..8");
  end

  rsx_state_t state;
  logic fire;
  logic [SKIP_CNT_W-1:0] skip_cnt;
  rsx_sum_t sub_r;
  logic [7:0] sub_b;
  logic sub_cin;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic sel_bit;
  logic next_acc_we;
  logic [7:0] next_acc;
  logic next_flags_we;
  rsx_flags_t next_flags;
  logic next_mem_we;
  logic [7:0] next_mem;
  logic next_skip;

  // an instruction is taken only outside the dummy cycle
  assign op_ready_out = (state == ST_READY);
  assign fire = ce_in && op_valid_in && op_ready_out;

  // shared adder: immediate or memory operand, carry-in 1 or c
  assign sub_b = (iss_in.op == OP_SUB_IMM) ? iss_in.imm : iss_in.mem;
  assign sub_cin = (iss_in.op == OP_SBC_ACC || iss_in.op == OP_SBC_MEM) ?
                   flags_out.c : 1'b1;
  assign sub_r = rsx_sub_f(acc_out, sub_b, sub_cin);
  assign dec_v = 8'(iss_in.mem - 8'h01);
  assign inc_v = 8'(iss_in.mem + 8'h01);
  assign sel_bit = iss_in.mem[iss_in.bit_sel];

  // per-operation result, destination and skip decision
  always_comb begin
    next_acc_we = 1'b0;
    next_acc = acc_out;
    next_flags_we = 1'b0;
    next_flags = flags_out;
    next_mem_we = 1'b0;
    next_mem = iss_in.mem;
    next_skip = 1'b0;
    unique case (iss_in.op)
      OP_RLC_MEM: begin
        next_mem_we = 1'b1;
        {next_flags.c, next_mem} = {iss_in.mem, flags_out.c};
        next_flags_we = 1'b1;
      end
      OP_RLC_ACC: begin
        next_acc_we = 1'b1;
        {next_flags.c, next_acc} = {iss_in.mem, flags_out.c};
        next_flags_we = 1'b1;
      end
      OP_RR_MEM: begin
        next_mem_we = 1'b1;
        next_mem = {iss_in.mem[0], iss_in.mem[7:1]};
      end
      OP_RR_ACC: begin
        next_acc_we = 1'b1;
        next_acc = {iss_in.mem[0], iss_in.mem[7:1]};
      end
      OP_RRC_MEM: begin
        next_mem_we = 1'b1;
        {next_mem, next_flags.c} = {flags_out.c, iss_in.mem};
        next_flags_we = 1'b1;
      end
      OP_RRC_ACC: begin
        next_acc_we = 1'b1;
        {next_acc, next_flags.c} = {flags_out.c, iss_in.mem};
        next_flags_we = 1'b1;
      end
      OP_SBC_ACC, OP_SUB_ACC, OP_SUB_IMM: begin
        next_acc_we = 1'b1;
        next_acc = sub_r.res;
        next_flags_we = 1'b1;
        next_flags = sub_r.flags;
      end
      OP_SBC_MEM, OP_SUB_MEM: begin
        next_mem_we = 1'b1;
        next_mem = sub_r.res;
        next_flags_we = 1'b1;
        next_flags = sub_r.flags;
      end
      OP_DSZ_MEM: begin
        next_mem_we = 1'b1;
        next_mem = dec_v;
        next_skip = (dec_v == 8'h00);
      end
      OP_DSZ_ACC: begin
        next_acc_we = 1'b1;
        next_acc = dec_v;
        next_skip = (dec_v == 8'h00);
      end
      OP_ISZ_MEM: begin
        next_mem_we = 1'b1;
        next_mem = inc_v;
        next_skip = (inc_v == 8'h00);
      end
      OP_ISZ_ACC: begin
        next_acc_we = 1'b1;
        next_acc = inc_v;
        next_skip = (inc_v == 8'h00);
      end
      OP_SKIP_BIT_NZ: begin
        next_skip = sel_bit;
      end
      OP_SET_BYTE: begin
        next_mem_we = 1'b1;
        next_mem = SET_BYTE_VAL;
      end
      OP_SET_BIT: begin
        next_mem_we = 1'b1;
        next_mem = iss_in.mem | (8'h01 << iss_in.bit_sel);
      end
      OP_SWAP: begin
        next_mem_we = 1'b1;
        next_mem = {iss_in.mem[3:0], iss_in.mem[7:4]};
      end
      OP_NOP: begin
        next_skip = 1'b0;
      end
      default: begin
        next_skip = 1'b0; // unused codes retire as no-ops
      end
    endcase
  end

  // accumulator: a retiring instruction beats a same-cycle port write
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      acc_out <= ACC_RST;
    end else if (ce_in) begin
      if (fire && next_acc_we) begin
        acc_out <= next_acc;
      end else if (reg_wr_in && reg_addr_in == REG_ACC) begin
        acc_out <= reg_wdata_in;
      end
    end
  end

  // status flags, same priority as the accumulator
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      flags_out <= FLAGS_RST;
    end else if (ce_in) begin
      if (fire && next_flags_we) begin
        flags_out <= next_flags;
      end else if (reg_wr_in && reg_addr_in == REG_STATUS) begin
        flags_out <= reg_wdata_in[3:0];
      end
    end
  end

  // memory write port: strobe one cycle, data held until the next write
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      mem_we_out <= 1'b0;
      mem_wdata_out <= 8'h00;
    end else if (ce_in) begin
      mem_we_out <= fire && next_mem_we;
      if (fire && next_mem_we) begin
        mem_wdata_out <= next_mem;
      end
    end
  end

  // sequencer: a taken skip adds one dummy cycle before retiring
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      state <= ST_READY;
      skip_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      if (fire) begin
        skip_out <= next_skip;
        done_out <= !next_skip;
        state <= next_skip ? ST_DUMMY : ST_READY;
      end else if (state == ST_DUMMY) begin
        skip_out <= 1'b0;
        done_out <= 1'b1;
        state <= ST_READY;
      end else begin
        skip_out <= 1'b0;
        done_out <= 1'b0;
      end
    end
  end

  // count of taken skips, wraps, cleared by a write to its address unless a skip is taken that cycle
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      skip_cnt <= '0;
    end else if (ce_in) begin
      if (fire && next_skip) begin
        skip_cnt <= skip_cnt + 1'b1;
      end else if (reg_wr_in && reg_addr_in == REG_SKIPS) begin
        skip_cnt <= '0;
      end
    end
  end

  // read data stand for the one cycle after the read strobe
  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          REG_ACC: reg_rdata_out <= acc_out;
          REG_STATUS: reg_rdata_out <= {4'h0, flags_out};
          REG_SKIPS: reg_rdata_out <= 8'(skip_cnt);
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // helpers that let the checks look back at the operands
  logic [7:0] in_mem;
  logic [2:0] in_bit;
  logic cur_c;
  assign in_mem = iss_in.mem;
  assign in_bit = iss_in.bit_sel;
  assign cur_c = flags_out.c;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);

  // nine-bit left rotate through carry written to memory
  property p_rlc_mem;
    fire && iss_in.op == OP_RLC_MEM |=>
      mem_we_out && {cur_c, mem_wdata_out} == {$past(in_mem), $past(cur_c)};
  endproperty
  a_rlc_mem: assert property (p_rlc_mem)
    else $error("left rotate through carry wrong");

  // nine-bit right rotate through carry written to memory
  property p_rrc_mem;
    fire && iss_in.op == OP_RRC_MEM |=>
      mem_we_out && {mem_wdata_out, cur_c} == {$past(cur_c), $past(in_mem)};
  endproperty
  a_rrc_mem: assert property (p_rrc_mem)
    else $error("right rotate through carry wrong");

  // subtract with borrow lands in the accumulator, memory untouched
  property p_sbc_acc;
    fire && iss_in.op == OP_SBC_ACC |=>
      !mem_we_out &&
      acc_out == 8'($past(acc_out) + ~$past(in_mem) + $past(cur_c));
  endproperty
  a_sbc_acc: assert property (p_sbc_acc)
    else $error("subtract with borrow result wrong");

  // decrement in place, skip exactly when the byte was one
  property p_dsz_mem;
    fire && iss_in.op == OP_DSZ_MEM |=>
      mem_we_out && mem_wdata_out == 8'($past(in_mem) - 8'h01) &&
      skip_out == ($past(in_mem) == 8'h01) && $stable(flags_out);
  endproperty
  a_dsz_mem: assert property (p_dsz_mem)
    else $error("decrement and skip wrong");

  // increment to accumulator, memory untouched, skip on wrap
  property p_isz_acc;
    fire && iss_in.op == OP_ISZ_ACC |=>
      !mem_we_out && acc_out == 8'($past(in_mem) + 8'h01) &&
      skip_out == ($past(in_mem) == 8'hff);
  endproperty
  a_isz_acc: assert property (p_isz_acc)
    else $error("increment to accumulator wrong");

  // taken skip: one dummy cycle with no new instruction, not yet retired
  property p_skip_taken;
    fire && next_skip |=> skip_out && !op_ready_out && !done_out;
  endproperty
  a_skip_taken: assert property (p_skip_taken)
    else $error("taken skip did not insert a dummy cycle");

  // untaken: retires after one cycle and is ready again
  property p_skip_not;
    fire && !next_skip |=> done_out && !skip_out && op_ready_out;
  endproperty
  a_skip_not: assert property (p_skip_not)
    else $error("untaken instruction did not retire in one cycle");

  // bit test skips on a one and changes nothing
  property p_bit_nz;
    fire && iss_in.op == OP_SKIP_BIT_NZ |=>
      !mem_we_out && $stable(acc_out) && $stable(flags_out) &&
      skip_out == $past(sel_bit);
  endproperty
  a_bit_nz: assert property (p_bit_nz)
    else $error("bit test skip wrong");

  // set bit keeps the other seven bits
  property p_set_bit;
    fire && iss_in.op == OP_SET_BIT |=>
      mem_we_out &&
      mem_wdata_out == ($past(in_mem) | (8'h01 << $past(in_bit)));
  endproperty
  a_set_bit: assert property (p_set_bit)
    else $error("set bit wrong");

  // nibble swap written back in place
  property p_swap;
    fire && iss_in.op == OP_SWAP |=>
      mem_we_out && mem_wdata_out[3:0] == $past(in_mem[7:4]) &&
      mem_wdata_out[7:4] == $past(in_mem[3:0]);
  endproperty
  a_swap: assert property (p_swap)
    else $error("nibble swap wrong");

endmodule

`default_nettype wire

/* src/rsx_pkg.sv */
/*
  rsx_pkg: shared types, constants and arithmetic for the rotate, subtract,
  skip, set and swap execute stage.
  assumes: imported by the execute stage and its testbench; no timescale here.
*/
package rsx_pkg;

  // operation codes delivered by the decoder
  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_RLC_MEM      = 5'h01,
    OP_RLC_ACC      = 5'h02,
    OP_RR_MEM       = 5'h03,
    OP_RR_ACC       = 5'h04,
    OP_RRC_MEM      = 5'h05,
    OP_RRC_ACC      = 5'h06,
    OP_SBC_ACC      = 5'h07,
    OP_SBC_MEM      = 5'h08,
    OP_DSZ_MEM      = 5'h09,
    OP_DSZ_ACC      = 5'h0a,
    OP_ISZ_MEM      = 5'h0b,
    OP_ISZ_ACC      = 5'h0c,
    OP_SKIP_BIT_NZ  = 5'h0d,
    OP_SET_BYTE     = 5'h0e,
    OP_SET_BIT      = 5'h0f,
    OP_SUB_ACC      = 5'h10,
    OP_SUB_MEM      = 5'h11,
    OP_SUB_IMM      = 5'h12,
    OP_SWAP         = 5'h13
  } rsx_op_t;

  // sequencer states, gray along ready -> dummy -> ready
  typedef enum logic {
    ST_READY = 1'b0,
    ST_DUMMY = 1'b1
  } rsx_state_t;

  // status flags, packed in the same order as the status register
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } rsx_flags_t;

  // one issued instruction with its operands
  typedef struct packed {
    rsx_op_t op;
    logic [7:0] mem;
    logic [7:0] imm;
    logic [2:0] bit_sel;
  } rsx_issue_t;

  // result of the shared add-complement adder
  typedef struct packed {
    rsx_flags_t flags;
    logic [7:0] res;
  } rsx_sum_t;

  // register map of the plain register port
  localparam logic [1:0] REG_ACC = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_SKIPS = 2'h2;

  // reset values and fixed data
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam rsx_flags_t FLAGS_RST = 4'h0;
  localparam logic [7:0] SET_BYTE_VAL = 8'hff;

  // cycles taken by a skip instruction, taken or not
  localparam int CYC_SKIP_TAKEN = 2;
  localparam int CYC_SKIP_NOT = 1;

  // a + ~b + cin with carry, nibble carry, zero and overflow
  function automatic rsx_sum_t rsx_sub_f(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic cin);
    logic [7:0] nb;
    logic [4:0] lo;
    logic [8:0] full;
    rsx_sum_t r;
    nb = ~b;
    lo = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
    r.res = full[7:0];
    r.flags.c = full[8];
    r.flags.ac = lo[4];
    r.flags.z = (full[7:0] == 8'h00);
    r.flags.ov = (a[7] == nb[7]) && (full[7] != a[7]);
    return r;
  endfunction

endpackage
